/* File: bench/apb_host_model.sv */
// Purpose: APB3 host that issues register transfers.
// Assumes: Requests change just after a rising edge.
// Notes: Idle address and data show inverted values.
`timescale 1ns/1ns
`default_nettype none

module apb_host_model
(
	input wire logic clk, // Clock.
	input wire logic pready, // Ready.
	input wire logic pslverr, // Error.
	input wire logic [31:0] prdata, // Read data.
	output logic psel, // Select.
	output logic penable, // Enable.
	output logic pwrite, // Write.
	output logic [11:0] paddr, // Address.
	output logic [31:0] pwdata // Write data.
);
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
	end

	// Software keeps power and self-refresh policy
	// Extra init delays are timed here by the caller
	task automatic xfer(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic er,
		output int w);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 300)
		begin
			n++;
			@(posedge clk);
		end
		rd = prdata;
		er = pslverr;
		w = n;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule

`default_nettype wire

/* File: bench/tb.sv */
// Purpose: Self-checking bench of the command-side control block.
// Assumes: Clock 10 MHz, reset high for 3 cycles.
// Notes: All bus stimulus goes through the host model; cmd_delay is driven directly.
`timescale 1ns/1ns
`default_nettype none

module tb;
	logic clk, rst;
	logic [3:0] cmd_delay;
	logic psel, penable, pwrite, pready, pslverr, refresh_req, arb_hold;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] state_status;
	sdram_cmd_pkg::mem_cmd_s mem_cmd, last_cmd;
	logic er;
	int w, fails, check_count, cmd_n, ref_n, cyc;

	sdram_cmd_ctrl sdram_cmd_ctrl_inst (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.cmd_delay(cmd_delay), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .state_status(state_status),
		.refresh_req(refresh_req), .arb_hold(arb_hold), .mem_cmd(mem_cmd));
	apb_host_model apb_host_model_inst (.clk(clk), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (mem_cmd.valid === 1'b1)
		begin
			last_cmd <= mem_cmd;
			cmd_n++;
		end
		if (refresh_req === 1'b1)
			ref_n++;
		if (cyc == 20000)
		begin
			fails++;
			stop_test();
		end
	end

	task automatic check(input string nm, input logic [31:0] s, e);
		check_count++;
		if (s !== e)
		begin
			fails++;
			$display("unexpected %s exp %h seen %h", nm, e, s);
		end
	endtask

	task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
		apb_host_model_inst.xfer(wr, a, d, rd, er, w);
	endtask

	task automatic st_cmd(input logic [2:0] c);
		acc(1'b1, 12'h004, {29'h0000_0000, c});
		repeat (6) @(posedge clk);
		#1;
	endtask

	task automatic t_states();
		check("rst state", state_status, 32'h0000_0000);
		st_cmd(3'h7);
		check("ready", state_status, 32'h0000_0001);
		check("hold ready", arb_hold, 32'h0000_0000);
		acc(1'b0, 12'h000, 32'h0000_0000);
		check("status rd", rd, 32'h0000_0001);
		acc(1'b0, 12'h004, 32'h0000_0000);
		check("wo err", er, 32'h0000_0001);
		acc(1'b1, 12'h004, 32'h0000_0003);
		@(posedge clk);
		#1;
		check("pause now", state_status, 32'h0000_0002);
		check("hold paused", arb_hold, 32'h0000_0001);
		st_cmd(3'h4);
		check("config", state_status, 32'h0000_0000);
	endtask

	task automatic t_stall();
		acc(1'b1, 12'h004, 32'h0000_0007);
		acc(1'b1, 12'h004, 32'h0000_0003);
		check("stalled", w != 0, 32'h0000_0001);
		repeat (2) @(posedge clk);
		#1;
		check("paused", state_status, 32'h0000_0002);
		st_cmd(3'h4);
	endtask

	task automatic direct(input logic [2:0] c, input logic ok);
		logic [1:0] ch;
		logic [13:0] ad;
		int n0;
		ch = c[1:0] ^ 2'b01;
		ad = 14'h2A5C ^ {11'h000, c};
		n0 = cmd_n;
		acc(1'b1, 12'h008, {9'h000, c[2], ch, c[1:0], 2'b10, 2'b00, ad});
		repeat (2) @(posedge clk);
		#1;
		check("dc err", er, {31'h0, !ok});
		check("dc count", cmd_n - n0, {31'h0, ok});
		if (ok)
			check("dc pins", last_cmd, {10'h000, 1'b1, c, ch,
				(c == 3'h2) ? {2'b10, ad} : 16'h0000});
	endtask

	task automatic t_direct();
		for (int i = 0; i < 5; i++)
			direct(i[2:0], 1'b1);
		cmd_delay <= 4'h0;
		direct(3'h3, 1'b1);
		direct(3'h1, 1'b1);
		check("no wait", w, 32'h0000_0000);
		// The next access phase comes 5 edges after the taken edge, so a
		// spacing of 15 cycles leaves 11 wait states.
		cmd_delay <= 4'hF;
		direct(3'h3, 1'b1);
		direct(3'h1, 1'b1);
		check("spacing", w, 32'h0000_000B);
	endtask

	task automatic refresh(input logic [31:0] e);
		ref_n = 0;
		repeat (1249) @(posedge clk);
		#1;
		check("refreshes", ref_n, e);
	endtask

	task automatic stop_test();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		rst = 1'b1;
		cmd_delay = 4'h3;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_states();
		t_stall();
		t_direct();
		refresh(32'h0000_0000);
		st_cmd(3'h7);
		direct(3'h3, 1'b0);
		refresh(32'h0000_0001);
		st_cmd(3'h1);
		check("lowpower", state_status, 32'h0000_0003);
		direct(3'h0, 1'b1);
		acc(1'b0, 12'h00C, 32'h0000_0000);
		check("unmapped", er, 32'h0000_0001);
		st_cmd(3'h2);
		check("wakeup", state_status, 32'h0000_0000);
		st_cmd(3'h5);
		check("ignored", state_status, 32'h0000_0000);
		stop_test();
	end
endmodule

`default_nettype wire

/* File: rtl/sdram_cmd_ctrl.sv */
// Purpose: State-command and direct-command registers of an SDRAM controller.
// Assumes: APB3 slave; a state change other than pause takes a fixed count of cycles.
// Notes: Both command registers are write-only; offset 0 reads the state.
`include "sdram_cmd_map.svh"
`timescale 1ns/1ns
`default_nettype none

module sdram_cmd_ctrl
(
	input wire logic clk, // Clock, 10 MHz.
	input wire logic rst, // Async reset, high.
	input wire logic psel, // APB3 select.
	input wire logic penable, // APB3 enable.
	input wire logic pwrite, // APB3 write.
	input wire logic [11:0] paddr, // APB3 byte address.
	input wire logic [31:0] pwdata, // APB3 write data.
	input wire logic [3:0] cmd_delay, // Programmed command spacing.
	output logic [31:0] prdata, // APB3 read data.
	output logic pready, // APB3 ready.
	output logic pslverr, // APB3 error.
	output logic [1:0] state_status, // Current state.
	output logic refresh_req, // Periodic refresh pulse.
	output logic arb_hold, // Arbiter queue held, not drained.
	output sdram_cmd_pkg::mem_cmd_s mem_cmd // Direct command on the pins.
);

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	sdram_cmd_pkg::apb_req_s bus;
	sdram_cmd_pkg::ctrl_state_e state_q;
	sdram_cmd_pkg::ctrl_state_e target_q;
	logic [3:0] trans_q;
	logic [11:0] ref_q;
	logic [2:0] scmd;
	logic acc;
	logic hit_status;
	logic hit_state;
	logic hit_direct;
	logic trans_busy;
	logic dcmd_ok;
	logic dcmd_go;
	logic scmd_go;
	logic issue_busy;
	sdram_cmd_pkg::mem_cmd_s dreq;
	sdram_cmd_pkg::ctrl_state_e next_target;

	assign bus = '{psel, penable, pwrite, paddr, pwdata};
	assign acc = bus.psel && bus.penable;
	assign hit_status = (bus.paddr == `STATUS_OFS);
	assign hit_state = (bus.paddr == `STATE_CMD_OFS);
	assign hit_direct = (bus.paddr == `DIRECT_CMD_OFS);
	assign scmd = bus.pwdata[`STATE_FIELD_HI:0];
	assign trans_busy = (trans_q != 4'h0);

	// ------------------------------------------------------------
	// State commands
	// ------------------------------------------------------------
	function automatic sdram_cmd_pkg::ctrl_state_e decode_state
	(
		input logic [2:0] c,
		input sdram_cmd_pkg::ctrl_state_e cur
	);
		if (c == `SCMD_PAUSE)
			decode_state = sdram_cmd_pkg::ST_PAUSED;
		else if (c == `SCMD_CONFIG)
			decode_state = sdram_cmd_pkg::ST_CONFIG;
		else if (c == `SCMD_ACTIVE)
			decode_state = sdram_cmd_pkg::ST_READY;
		else if (c == `SCMD_SLEEP)
			decode_state = sdram_cmd_pkg::ST_LOWPOWER;
		else if (c == `SCMD_WAKEUP)
			decode_state = sdram_cmd_pkg::ST_CONFIG;
		else
			decode_state = cur;
	endfunction

	assign next_target = decode_state(scmd, target_q);
	// A new state command waits while the previous one is still running.
	assign scmd_go = acc && bus.pwrite && hit_state && !trans_busy;
	assign dcmd_ok = (state_q == sdram_cmd_pkg::ST_CONFIG)
		|| (state_q == sdram_cmd_pkg::ST_LOWPOWER);
	assign dcmd_go = acc && bus.pwrite && hit_direct && dcmd_ok && !issue_busy;

	// ------------------------------------------------------------
	// Bus answer
	// ------------------------------------------------------------
	// Direct writes stall only for spacing; writes outside the allowed states
	// complete with an error instead of hanging the bus.
	assign pready = !(acc && bus.pwrite && hit_state && trans_busy)
		&& !(acc && bus.pwrite && hit_direct && dcmd_ok && issue_busy);
	assign pslverr = acc && pready && ((bus.pwrite && hit_direct && !dcmd_ok)
		|| !(hit_status || hit_state || hit_direct)
		|| (!bus.pwrite && !hit_status));
	assign state_status = state_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			prdata <= 32'h0000_0000;
		else
			prdata <= {30'h0000_0000, state_q};
	end

	// ------------------------------------------------------------
	// State machine
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= sdram_cmd_pkg::ST_CONFIG;
			target_q <= sdram_cmd_pkg::ST_CONFIG;
			trans_q <= 4'h0;
		end
		else if (scmd_go)
		begin
			target_q <= next_target;
			// Pause takes effect at once; a change to another state runs the transition count.
			if (next_target == sdram_cmd_pkg::ST_PAUSED)
			begin
				state_q <= sdram_cmd_pkg::ST_PAUSED;
				trans_q <= 4'h0;
			end
			else
				trans_q <= (next_target == state_q) ? 4'h0 : `STATE_TRANS_CYC;
		end
		else if (trans_busy)
		begin
			trans_q <= trans_q - 4'h1;
			if (trans_q == 4'h1)
				state_q <= target_q;
		end
	end

	// Queued requests stay in the arbiter in every state except ready.
	assign arb_hold = (state_q != sdram_cmd_pkg::ST_READY);

	// ------------------------------------------------------------
	// Refresh timer
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ref_q <= 12'h0_000;
			refresh_req <= 1'b0;
		end
		else if (state_q == sdram_cmd_pkg::ST_CONFIG)
		begin
			ref_q <= 12'h0_000;
			refresh_req <= 1'b0;
		end
		else
		begin
			ref_q <= (ref_q == `REFRESH_PERIOD_CYC) ? 12'h0_000 : ref_q + 12'h0_001;
			refresh_req <= (ref_q == `REFRESH_PERIOD_CYC)
				&& (state_q != sdram_cmd_pkg::ST_LOWPOWER);
		end
	end

	// ------------------------------------------------------------
	// Direct commands
	// ------------------------------------------------------------
	assign dreq.valid = dcmd_go;
	assign dreq.code = sdram_cmd_pkg::direct_code_e'({bus.pwdata[`DCMD_EXT_BIT],
		bus.pwdata[`DCMD_CODE_HI:`DCMD_CODE_LO]});
	assign dreq.chip = bus.pwdata[`DCMD_CHIP_HI:`DCMD_CHIP_LO];
	// Bank and address lines carry the fields only for a mode-register write.
	assign dreq.bank = (dreq.code == sdram_cmd_pkg::DC_MODE_REG) ?
		bus.pwdata[`DCMD_BANK_HI:`DCMD_BANK_LO] : 2'h0;
	assign dreq.addr = (dreq.code == sdram_cmd_pkg::DC_MODE_REG) ?
		bus.pwdata[`DCMD_ADDR_HI:0] : 14'h0000;

	sdram_cmd_issue u_issue
	(
		.clk(clk),
		.rst(rst),
		.req(dreq),
		.cmd_delay(cmd_delay),
		.busy(issue_busy),
		.mem_cmd(mem_cmd)
	);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_wait_busy;
		@(posedge clk) disable iff (rst)
		(acc && bus.pwrite && hit_state && trans_busy) |-> !pready;
	endproperty
	a_wait_busy: assert property (p_wait_busy) else $error("no wait");

	property p_pause_now;
		@(posedge clk) disable iff (rst)
		(scmd_go && scmd == `SCMD_PAUSE) |=> state_q == sdram_cmd_pkg::ST_PAUSED;
	endproperty
	a_pause_now: assert property (p_pause_now) else $error("pause late");

	property p_cfg_trans;
		@(posedge clk) disable iff (rst)
		(scmd_go && scmd == `SCMD_CONFIG && state_q != sdram_cmd_pkg::ST_CONFIG)
		|-> ##5 state_q == sdram_cmd_pkg::ST_CONFIG;
	endproperty
	a_cfg_trans: assert property (p_cfg_trans) else $error("config late");

	property p_act_trans;
		@(posedge clk) disable iff (rst)
		(scmd_go && scmd == `SCMD_ACTIVE && state_q != sdram_cmd_pkg::ST_READY)
		|-> ##5 state_q == sdram_cmd_pkg::ST_READY;
	endproperty
	a_act_trans: assert property (p_act_trans) else $error("active late");

	property p_no_ref_cfg;
		@(posedge clk) disable iff (rst)
		state_q == sdram_cmd_pkg::ST_CONFIG |=> !refresh_req;
	endproperty
	a_no_ref_cfg: assert property (p_no_ref_cfg) else $error("refresh");

	property p_dcmd_state;
		@(posedge clk) disable iff (rst)
		mem_cmd.valid |-> $past(dcmd_ok);
	endproperty
	a_dcmd_state: assert property (p_dcmd_state) else $error("bad state");

	property p_chip_map;
		@(posedge clk) disable iff (rst)
		dcmd_go |=> mem_cmd.chip == $past(bus.pwdata[21:20]);
	endproperty
	a_chip_map: assert property (p_chip_map) else $error("chip");

	property p_mode_addr;
		@(posedge clk) disable iff (rst)
		(dcmd_go && dreq.code == sdram_cmd_pkg::DC_MODE_REG) |=>
		mem_cmd.addr == $past(bus.pwdata[13:0])
		&& mem_cmd.bank == $past(bus.pwdata[17:16]);
	endproperty
	a_mode_addr: assert property (p_mode_addr) else $error("addr");

	property p_code_ext;
		@(posedge clk) disable iff (rst)
		dcmd_go |=> mem_cmd.code[2] == $past(bus.pwdata[22]);
	endproperty
	a_code_ext: assert property (p_code_ext) else $error("ext bit");

	property p_status;
		@(posedge clk) disable iff (rst)
		1'b1 |=> prdata[1:0] == $past(state_status);
	endproperty
	a_status: assert property (p_status) else $error("status");

endmodule
`default_nettype wire

/* File: rtl/sdram_cmd_issue.sv */
// Purpose: Issues direct commands to the SDRAM pins with a spacing delay.
// Assumes: One request at a time; busy is honoured by the caller.
// Notes: The only spacing is the programmed command delay.
`include "sdram_cmd_map.svh"
`timescale 1ns/1ns
`default_nettype none

module sdram_cmd_issue
(
	input wire logic clk, // Clock.
	input wire logic rst, // Async reset, high.
	input var sdram_cmd_pkg::mem_cmd_s req, // Command request.
	input wire logic [3:0] cmd_delay, // Cycles between commands.
	output logic busy, // Spacing delay running.
	output sdram_cmd_pkg::mem_cmd_s mem_cmd // Command on the pins.
);

	logic [3:0] gap_q;
	logic [3:0] gap_d;
	sdram_cmd_pkg::mem_cmd_s out_d;

	assign busy = (gap_q != 4'h0);
	// Only the programmed delay holds off the next command.
	assign gap_d = req.valid ? cmd_delay : (busy ? gap_q - 4'h1 : 4'h0);
	assign out_d = req;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			gap_q <= 4'h0;
			mem_cmd <= '0;
		end
		else
		begin
			gap_q <= gap_d;
			mem_cmd <= out_d;
		end
	end

	property p_gap_load;
		@(posedge clk) disable iff (rst)
		req.valid |=> gap_q == $past(cmd_delay);
	endproperty
	a_gap_load: assert property (p_gap_load) else $error("gap not loaded");

	property p_pin_follow;
		@(posedge clk) disable iff (rst)
		req.valid |=> mem_cmd.valid && mem_cmd.code == $past(req.code);
	endproperty
	a_pin_follow: assert property (p_pin_follow) else $error("cmd not issued");

endmodule
`default_nettype wire

/* File: rtl/sdram_cmd_map.svh */
// Purpose: Register offsets, field positions, codes and timing counts.
// Assumes: APB3 register port with 12-bit byte addresses.
// Notes: Included by the design modules, not by the package.
`ifndef SDRAM_CMD_MAP_SVH
`define SDRAM_CMD_MAP_SVH

`define STATUS_OFS 12'h000
`define STATE_CMD_OFS 12'h004
`define DIRECT_CMD_OFS 12'h008
`define STATE_FIELD_HI 2
`define DCMD_EXT_BIT 22
`define DCMD_CHIP_HI 21
`define DCMD_CHIP_LO 20
`define DCMD_CODE_HI 19
`define DCMD_CODE_LO 18
`define DCMD_BANK_HI 17
`define DCMD_BANK_LO 16
`define DCMD_ADDR_HI 13
`define SCMD_WAKEUP 3'h2
`define SCMD_PAUSE 3'h3
`define SCMD_CONFIG 3'h4
`define SCMD_ACTIVE 3'h7
`define SCMD_SLEEP 3'h1
`define STATE_TRANS_CYC 4'h4
`define REFRESH_PERIOD_CYC 12'h0_4E0
`define CMD_DELAY_RESET 4'h2

`endif

/* File: rtl/sdram_cmd_pkg.sv */
// Purpose: Types shared by the command-side control block.
// Assumes: Constants come from sdram_cmd_map.svh.
// Notes: Holds types only.
`default_nettype none

package sdram_cmd_pkg;

	typedef enum logic [1:0]
	{
		ST_CONFIG = 2'h0,
		ST_READY = 2'h1,
		ST_PAUSED = 2'h2,
		ST_LOWPOWER = 2'h3
	} ctrl_state_e;

	typedef enum logic [2:0]
	{
		DC_PRECHARGE_ALL = 3'h0,
		DC_AUTO_REFRESH = 3'h1,
		DC_MODE_REG = 3'h2,
		DC_NOP = 3'h3,
		DC_DEEP_PDOWN = 3'h4
	} direct_code_e;

	typedef struct packed
	{
		logic valid;
		direct_code_e code;
		logic [1:0] chip;
		logic [1:0] bank;
		logic [13:0] addr;
	} mem_cmd_s;

	typedef struct packed
	{
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;

endpackage

`default_nettype wire
